// ===== digital_output_port_regs.svh
// register offsets, field positions, reset values and counts of the output port
`ifndef DIGITAL_OUTPUT_PORT_REGS_SVH
`define DIGITAL_OUTPUT_PORT_REGS_SVH

// register byte offsets
`define OFS_BANK0        8'h00
`define OFS_BIT_INDEX    8'h18
`define OFS_BIT_VALUE    8'h1C
`define OFS_BIT_SET      8'h20
`define OFS_BIT_CLEAR    8'h24
`define OFS_OUT_LOW      8'h28
`define OFS_OUT_HIGH     8'h2C
`define OFS_CONFIG       8'h30
`define OFS_STATUS       8'h34

// reset values
`define RST_BANK         8'h00
`define RST_OUTPUTS      48'h0
`define RST_CONFIG       4'h0
`define RST_INDEX        22'h0

// config fields
`define CFG_EXP_BIT      0
`define CFG_DIR_LSB      1
`define CFG_DIR_MSB      3

// status fields
`define STS_REJECT_BIT   0
`define STS_SLAVE_LSB    8
`define STS_HANDLE_LSB   16
`define STS_MODULE_LSB   20
`define STS_POINT_LSB    25

// sizes
`define NUM_BANKS        6
`define BASE_BANKS       3
`define BANK_WIDTH       8
`define NUM_OUTPUTS      48

// packed remote index weights and limits
`define SLAVE_WEIGHT     22'd10000
`define HANDLE_WEIGHT    22'd1000
`define REMOTE_FLOOR     22'd1000
`define SLAVE_MAX        22'd255
`define MODULE_SPAN      22'd64

`endif

// ===== digital_output_port_pkg.sv
// types shared by the output port modules
package digital_output_port_pkg;

   typedef logic [7:0]  bank_t;
   typedef logic [21:0] bit_index_t;
   typedef logic [47:0] outputs_t;

   typedef enum logic [1:0] {
      BIT_NONE  = 2'b00,
      BIT_SET   = 2'b01,
      BIT_VALUE = 2'b11,
      BIT_CLEAR = 2'b10
   } bit_op_t;

endpackage

// ===== remote_index_decode.sv
// splits a packed decimal bit index into remote slave, handle, module, point
`timescale 1ns/1ps
`include "digital_output_port_regs.svh"

module remote_index_decode (
   // packed index
   input  wire logic [21:0] index,
   // decoded fields
   output logic             is_remote,
   output logic             remote_ok,
   output logic [7:0]       slave,
   output logic [3:0]       handle,
   output logic [4:0]       module_pos,
   output logic [2:0]       point
);
   logic [21:0] q_slave;
   logic [21:0] rem_slave;
   logic [21:0] q_handle;
   logic [21:0] rem_handle;
   logic [21:0] module_idx;

   assign q_slave    = index / `SLAVE_WEIGHT;
   assign rem_slave  = index - q_slave * `SLAVE_WEIGHT;
   assign q_handle   = rem_slave / `HANDLE_WEIGHT;
   assign rem_handle = rem_slave - q_handle * `HANDLE_WEIGHT;
   assign module_idx = rem_handle >> 2;

   assign is_remote  = index >= `REMOTE_FLOOR;
   // slave 0..255, handle counts from 1, at most 16 modules of 4 points
   assign remote_ok  = is_remote && (q_slave <= `SLAVE_MAX)
                       && (q_handle != 22'd0)
                       && (rem_handle < `MODULE_SPAN);

   assign slave      = q_slave[7:0];
   assign handle     = q_handle[3:0];
   assign module_pos = 5'(module_idx[3:0]) + 5'h01;
   assign point      = 3'(rem_handle[1:0]) + 3'h1;

endmodule

// ===== output_banks.sv
// storage for 48 outputs in six banks with bank readback values
`timescale 1ns/1ps
`include "digital_output_port_regs.svh"

module output_banks (
   // clock and reset
   input  wire logic                                  core_clk,
   input  wire logic                                  reset_n,
   // bank writes
   input  wire logic [5:0]                            bank_we,
   input  wire digital_output_port_pkg::bank_t        bank_data,
   input  wire logic [5:0]                            bank_block,
   // single bit writes
   input  wire logic                                  bit_we,
   input  wire logic [5:0]                            bit_idx,
   input  wire logic                                  bit_val,
   // state
   output digital_output_port_pkg::outputs_t          out_state,
   output logic [47:0]                                bank_last
);
   import digital_output_port_pkg::*;

   genvar b;
   genvar k;
   generate
      for (b = 0; b < `NUM_BANKS; b = b + 1) begin : g_bank
         // readback keeps the pattern even when the bank is an input
         always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               bank_last[b*8 +: 8] <= `RST_BANK;
            end else if (bank_we[b]) begin
               bank_last[b*8 +: 8] <= bank_data;
            end
         end
         for (k = 0; k < `BANK_WIDTH; k = k + 1) begin : g_bit
            logic hit;
            assign hit = bit_we && (bit_idx == 6'(b * 8 + k));
            always_ff @(posedge core_clk or negedge reset_n) begin
               if (!reset_n) begin
                  out_state[b*8 + k] <= 1'b0;
               end else if (bank_we[b] && !bank_block[b]) begin
                  out_state[b*8 + k] <= bank_data[k];
               end else if (hit) begin
                  out_state[b*8 + k] <= bit_val;
               end
            end
         end
      end
   endgenerate

endmodule

// ===== digital_output_port.sv
// digital output port: apb registers, bank and bit writes, remote decode
// Functional notes
// - a single-bit write drives the addressed output to 1 or 0.
// - any non-zero value drives high; only exactly zero drives low.
// - remote index = slave*10000 + handle*1000 + 4*(module-1) + point-1.
// - slave field 0 to 255, usually zero; handle counts from 1.
// - module field selects rack position 1 to 16.
// - point field selects one of four points, 1 to 4.
// - a bank write sets all eight bank outputs from a 0..255 pattern.
// - banks 0, 1, 2 drive outputs 0-7, 8-15, 16-23.
// - with expansion option, banks 3, 4, 5 drive outputs 24-47.
// - expansion banks set as inputs ignore bank write patterns.
// - each bank keeps its last written pattern for readback.
// - set, clear and value writes touch only the addressed bit.
// - every output's present state is readable.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "digital_output_port_regs.svh"

module digital_output_port (
   // clock and reset
   input  wire logic                              core_clk,
   input  wire logic                              reset_n,
   // apb slave
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [7:0]                        paddr,
   input  wire logic [31:0]                       pwdata,
   output logic [31:0]                            prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   // output pins
   output digital_output_port_pkg::outputs_t      out_state,
   // remote output requests
   output logic                                   remote_strobe,
   output logic [7:0]                             remote_slave,
   output logic [3:0]                             remote_handle,
   output logic [4:0]                             remote_module,
   output logic [2:0]                             remote_point,
   output logic                                   remote_value
);
   import digital_output_port_pkg::*;

   // bus phases
   wire         setup_phase;
   wire         access_phase;
   wire         write_access;
   assign setup_phase  = psel && !penable;
   assign access_phase = psel && penable;
   assign write_access = access_phase && pwrite;

   // address decode
   wire [2:0]   bank_sel;
   wire         hit_bank;
   wire         hit_index;
   wire         hit_value;
   wire         hit_set;
   wire         hit_clear;
   wire         hit_out_low;
   wire         hit_out_high;
   wire         hit_config;
   wire         hit_status;
   wire         mapped;
   assign bank_sel     = paddr[4:2];
   assign hit_bank     = (paddr[7:5] == 3'h0)
                         && (bank_sel < 3'(`NUM_BANKS));
   assign hit_index    = paddr[7:2] == `OFS_BIT_INDEX >> 2;
   assign hit_value    = paddr[7:2] == `OFS_BIT_VALUE >> 2;
   assign hit_set      = paddr[7:2] == `OFS_BIT_SET >> 2;
   assign hit_clear    = paddr[7:2] == `OFS_BIT_CLEAR >> 2;
   assign hit_out_low  = paddr[7:2] == `OFS_OUT_LOW >> 2;
   assign hit_out_high = paddr[7:2] == `OFS_OUT_HIGH >> 2;
   assign hit_config   = paddr[7:2] == `OFS_CONFIG >> 2;
   assign hit_status   = paddr[7:2] == `OFS_STATUS >> 2;
   assign mapped       = hit_bank || hit_index || hit_value || hit_set
                         || hit_clear || hit_out_low || hit_out_high
                         || hit_config || hit_status;

   // software state
   bit_index_t  bit_index;
   logic [3:0]  config_bits;
   logic        reject;
   logic [7:0]  last_slave;
   logic [3:0]  last_handle;
   logic [4:0]  last_module;
   logic [2:0]  last_point;

   wire         exp_present;
   wire [2:0]   exp_is_input;
   assign exp_present  = config_bits[`CFG_EXP_BIT];
   assign exp_is_input = config_bits[`CFG_DIR_MSB:`CFG_DIR_LSB];

   // banks 3..5 drive only with the expansion option and as outputs
   wire [5:0]   bank_block;
   wire [5:0]   bank_absent;
   genvar       g;
   // banks below the expansion are always fitted
   generate
      for (g = 0; g < `NUM_BANKS; g = g + 1) begin : g_gate
         if (g < `BASE_BANKS) begin : g_base
            assign bank_block[g]  = 1'b0;
            assign bank_absent[g] = 1'b0;
         end else begin : g_exp
            assign bank_absent[g] = ~exp_present;
            assign bank_block[g]  = ~exp_present
                                    | exp_is_input[g - `BASE_BANKS];
         end
      end
   endgenerate

   // bank writes
   wire         write_bank;
   wire [5:0]   bank_we;
   assign write_bank = write_access && hit_bank;
   assign bank_we    = write_bank ? 6'(6'h01 << bank_sel) : 6'h00;

   // single bit operation, one per write, decoded from its address
   wire         write_set;
   wire         write_clear;
   wire         write_value;
   bit_op_t     bit_op;
   bit_index_t  target;
   assign write_set   = write_access && hit_set;
   assign write_clear = write_access && hit_clear;
   assign write_value = write_access && hit_value;
   assign bit_op = write_set   ? BIT_SET
                 : write_clear ? BIT_CLEAR
                 : write_value ? BIT_VALUE
                 : BIT_NONE;
   // the value command takes the stored index, set and clear the data
   assign target = hit_value ? bit_index : pwdata[21:0];

   wire         is_remote;
   wire         remote_ok;
   wire [7:0]   dec_slave;
   wire [3:0]   dec_handle;
   wire [4:0]   dec_module;
   wire [2:0]   dec_point;

   remote_index_decode u_decode (
      .index      (target),
      .is_remote  (is_remote),
      .remote_ok  (remote_ok),
      .slave      (dec_slave),
      .handle     (dec_handle),
      .module_pos (dec_module),
      .point      (dec_point)
   );

   // value written by the bit command
   wire         bit_level;
   assign bit_level = (bit_op == BIT_SET)
                      || ((bit_op == BIT_VALUE) && (pwdata != 32'h0));

   wire         local_in_range;
   wire [2:0]   target_bank;
   wire         local_ok;
   wire         local_we;
   wire         bit_bad;
   wire         op_active;
   // local bits lie below 48, banks 3..5 only with the option
   assign op_active      = bit_op != BIT_NONE;
   assign local_in_range = !is_remote && (target < 22'(`NUM_OUTPUTS));
   assign target_bank    = target[5:3];
   assign local_ok       = local_in_range && !bank_absent[target_bank];
   // a bit of an input-configured bank is ignored, not rejected
   assign local_we       = op_active && local_ok
                           && !bank_block[target_bank];
   assign bit_bad        = is_remote ? !remote_ok : !local_ok;

   wire [47:0]  bank_last;

   output_banks u_banks (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .bank_we    (bank_we),
      .bank_data  (pwdata[7:0]),
      .bank_block (bank_block),
      .bit_we     (local_we),
      .bit_idx    (target[5:0]),
      .bit_val    (bit_level),
      .out_state  (out_state),
      .bank_last  (bank_last)
   );

   // software registers
   wire         write_index;
   wire         write_config;
   assign write_index  = write_access && hit_index;
   assign write_config = write_access && hit_config;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         bit_index   <= `RST_INDEX;
         config_bits <= `RST_CONFIG;
      end else begin
         if (write_index) begin
            bit_index <= pwdata[21:0];
         end
         if (write_config) begin
            config_bits <= pwdata[3:0];
         end
      end
   end

   // an accepted remote command updates the request and the status fields
   wire         remote_take;
   wire         next_reject;
   wire [7:0]   next_slave;
   wire [3:0]   next_handle;
   wire [4:0]   next_module;
   wire [2:0]   next_point;
   wire         next_value;
   assign remote_take = op_active && is_remote && remote_ok;
   // every bit command records whether it was refused
   assign next_reject = op_active ? bit_bad : reject;

   assign next_slave  = remote_take ? dec_slave  : remote_slave;
   assign next_handle = remote_take ? dec_handle : remote_handle;
   assign next_module = remote_take ? dec_module : remote_module;
   assign next_point  = remote_take ? dec_point  : remote_point;
   assign next_value  = remote_take ? bit_level  : remote_value;

   // status: refusal of the last bit command, fields of the last accepted remote command
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reject      <= 1'b0;
         last_slave  <= 8'h00;
         last_handle <= 4'h0;
         last_module <= 5'h00;
         last_point  <= 3'h0;
      end else begin
         reject      <= next_reject;
         last_slave  <= next_slave;
         last_handle <= next_handle;
         last_module <= next_module;
         last_point  <= next_point;
      end
   end

   // remote request, one cycle per accepted remote bit command
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         remote_strobe <= 1'b0;
         remote_slave  <= 8'h00;
         remote_handle <= 4'h0;
         remote_module <= 5'h00;
         remote_point  <= 3'h0;
         remote_value  <= 1'b0;
      end else begin
         remote_strobe <= remote_take;
         remote_slave  <= next_slave;
         remote_handle <= next_handle;
         remote_module <= next_module;
         remote_point  <= next_point;
         remote_value  <= next_value;
      end
   end

   // read selection
   wire [31:0]  bank_word;
   wire [31:0]  index_word;
   wire [31:0]  low_word;
   wire [31:0]  high_word;
   wire [31:0]  config_word;
   wire [31:0]  status_word;
   wire [31:0]  read_word;
   wire [31:0]  next_prdata;
   assign bank_word   = {24'h0, bank_last[{bank_sel, 3'b000} +: 8]};
   assign index_word  = {10'h0, bit_index};
   assign low_word    = out_state[31:0];
   assign high_word   = {16'h0, out_state[47:32]};
   assign config_word = {28'h0, config_bits};
   assign status_word = {4'h0, last_point, last_module, last_handle,
                         last_slave, 7'h00, reject};

   assign read_word =
        hit_bank     ? bank_word
      : hit_index    ? index_word
      : hit_out_low  ? low_word
      : hit_out_high ? high_word
      : hit_config   ? config_word
      : hit_status   ? status_word
      : 32'h0;
   // a write setup loads zero so write cycles never show stale data
   assign next_prdata = pwrite ? 32'h0 : read_word;

   // read data is captured in the setup cycle and shown in the access cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h0;
      end else if (setup_phase) begin
         prdata <= next_prdata;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = access_phase && !mapped;

endmodule

// ===== digital_output_port_props.sv
// port assertions for the digital output port
`timescale 1ns/1ps
module digital_output_port_props (
   // clock and reset
   input wire logic                              core_clk,
   input wire logic                              reset_n,
   // apb
   input wire logic                              psel,
   input wire logic                              penable,
   input wire logic                              pwrite,
   input wire logic [7:0]                        paddr,
   input wire logic [31:0]                       pwdata,
   input wire logic [31:0]                       prdata,
   input wire logic                              pready,
   input wire logic                              pslverr,
   // pins and remote requests
   input wire digital_output_port_pkg::outputs_t out_state,
   input wire logic                              remote_strobe,
   input wire logic [7:0]                        remote_slave,
   input wire logic [3:0]                        remote_handle,
   input wire logic [4:0]                        remote_module,
   input wire logic [2:0]                        remote_point,
   input wire logic                              remote_value
);
   import digital_output_port_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   wire wr = psel && penable && pwrite;
   chk_bank_low: assert property (wr && paddr == 8'h00 |=>
      out_state[7:0] == $past(pwdata[7:0])) else $error("bank 0 pins");
   chk_bank_mid: assert property (wr && paddr == 8'h04 |=>
      out_state[15:8] == $past(pwdata[7:0])) else $error("bank 1 pins");
   chk_bank_two: assert property (wr && paddr == 8'h08 |=>
      out_state[23:16] == $past(pwdata[7:0])) else $error("bank 2 pins");
   chk_bit_set: assert property (wr && paddr == 8'h20
      && pwdata[21:0] < 24 |=> out_state[$past(pwdata[4:0])])
      else $error("set bit not high");
   chk_bit_clear: assert property (wr && paddr == 8'h24
      && pwdata[21:0] < 24 |=> !out_state[$past(pwdata[4:0])])
      else $error("clear bit not low");
   chk_quiet_hold: assert property (!wr |=> $stable(out_state))
      else $error("pins moved without a write");
   chk_read_state: assert property (psel && !penable
      && !pwrite && paddr == 8'h28 |=> prdata == $past(out_state[31:0]))
      else $error("low output read wrong");
   chk_remote_one: assert property (wr && paddr == 8'h20
      && pwdata[21:0] == 22'd1001 |=> remote_strobe && remote_value
      && remote_handle == 4'd1 && remote_module == 5'd1
      && remote_point == 3'd2) else $error("remote 1001 fields");
   chk_remote_max: assert property (wr && paddr == 8'h24
      && pwdata[21:0] == 22'd2559063 |=> remote_slave == 8'd255
      && remote_module == 5'd16 && remote_point == 3'd4 && !remote_value)
      else $error("remote top fields");
   chk_remote_bad: assert property (wr && paddr == 8'h20
      && pwdata[21:0] == 22'd1064 |=> !remote_strobe)
      else $error("bad remote index accepted");
endmodule

// ===== test_digital_output_port.sv
// self-checking bench for the digital output port
`timescale 1ns/1ps
module test_digital_output_port;
   import digital_output_port_pkg::*;
   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, rs, rv, e;
   outputs_t    out_state, exp;
   logic [7:0]  rsl;
   logic [3:0]  rh;
   logic [4:0]  rm;
   logic [2:0]  rp;
   logic [31:0] seed = 32'hFFA7D7C8;
   logic [31:0] r;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          tsl[4] = '{0, 255, 3, 0};
   int          th[4] = '{1, 9, 2, 1};
   int          tm[4] = '{1, 16, 7, 17};
   int          tp[4] = '{2, 4, 1, 1};
   always #4 core_clk = ~core_clk;
   digital_output_port u_dut (.core_clk, .reset_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .out_state,
      .remote_strobe(rs), .remote_slave(rsl), .remote_handle(rh),
      .remote_module(rm), .remote_point(rp), .remote_value(rv));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // packed remote index from its four fields
   function automatic logic [21:0] rix(int b);
      return 22'(tsl[b] * 10000 + th[b] * 1000 + 4 * (tm[b] - 1) + tp[b] - 1);
   endfunction
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [47:0] seen, logic [47:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, want, seen);
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int i;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_errors++;
         conclude();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // pins and both output readbacks against the model
   task automatic see(string nm);
      #1;
      chk(nm, out_state, exp);
      apb(1'b0, 8'h28, 32'h0);
      chk("out_low", {16'h0, r}, {16'h0, exp[31:0]});
      chk("read_err", 48'(e), 48'h0);
      apb(1'b0, 8'h2C, 32'h0);
      chk("out_high", {16'h0, r}, {32'h0, exp[47:32]});
   endtask
   initial begin
      int b;
      int i;
      logic [7:0] d;
      logic [21:0] ix;
      logic [31:0] v;
      exp = '0;
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      see("reset");
      for (b = 0; b < 6; b++) begin
         apb(1'b0, 8'(4 * b), 32'h0);
         chk("bank_reset", {16'h0, r}, 48'h0);
      end
      $display("test reset done");
      apb(1'b1, 8'h30, 32'h1);
      for (b = 0; b < 6; b++) begin
         d = b == 0 ? 8'hFF : b == 1 ? 8'h85 : 8'(rnd());
         apb(1'b1, 8'(4 * b), {24'h0, d});
         exp[8 * b +: 8] = d;
         see("bank");
         apb(1'b0, 8'(4 * b), 32'h0);
         chk("bank_back", {16'h0, r}, {40'h0, d});
      end
      $display("test banks done");
      // one expansion bank at a time turned to input ignores its pattern
      for (b = 3; b < 6; b++) begin
         apb(1'b1, 8'h30, 32'h1 | 32'h1 << (b - 2));
         for (i = 3; i < 6; i++) begin
            d = ~exp[8 * i +: 8];
            apb(1'b1, 8'(4 * i), {24'h0, d});
            if (i != b) exp[8 * i +: 8] = d;
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("in_back", {16'h0, r}, {40'h0, d});
         end
         see("in_bank");
      end
      apb(1'b1, 8'h30, 32'h1);
      $display("test input bank done");
      repeat (16) begin
         ix = 22'(rnd() % 48);
         v = rnd();
         case (v[1:0])
            2'd0: begin
               apb(1'b1, 8'h20, {10'h0, ix});
               exp[ix] = 1'b1;
            end
            2'd1: begin
               apb(1'b1, 8'h24, {10'h0, ix});
               exp[ix] = 1'b0;
            end
            default: begin
               apb(1'b1, 8'h18, {10'h0, ix});
               v = v[2] ? 32'h1 << v[7:3] : 32'h0;
               apb(1'b1, 8'h1C, v);
               exp[ix] = v != 32'h0;
            end
         endcase
         see("bit");
      end
      apb(1'b1, 8'h20, 32'd48);
      see("bit_reject");
      $display("test bits done");
      for (b = 0; b < 4; b++) begin
         apb(1'b1, b == 1 ? 8'h24 : 8'h20, {10'h0, rix(b)});
         #1;
         chk("strobe", 48'(rs), 48'(b < 3));
         if (b < 3) chk("fields", 48'({rsl, rh, rm, rp, rv}),
            48'({8'(tsl[b]), 4'(th[b]), 5'(tm[b]), 3'(tp[b]), b != 1}));
         @(posedge core_clk);
         #1;
         chk("strobe_end", 48'(rs), 48'h0);
      end
      see("remote");
      apb(1'b0, 8'h34, 32'h0);
      chk("status", {16'h0, r}, 48'({3'(tp[2]), 5'(tm[2]),
         4'(th[2]), 8'(tsl[2]), 8'h01}));
      $display("test remote done");
      apb(1'b1, 8'h40, 32'hFF);
      chk("err", 48'(e), 48'h1);
      see("unmapped");
      @(posedge core_clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      exp = '0;
      see("reset_again");
      apb(1'b1, 8'h0C, 32'hFF);
      see("absent");
      apb(1'b0, 8'h0C, 32'h0);
      chk("absent_back", {16'h0, r}, 48'hFF);
      $display("test errors and reset done");
      conclude();
   end
endmodule
bind digital_output_port digital_output_port_props u_props (.core_clk,
   .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .out_state, .remote_strobe, .remote_slave, .remote_handle,
   .remote_module, .remote_point, .remote_value);
